/* shared/ccpfr_map.vh */
// Purpose: Index map, field positions, reset values and timing counts of the card controller power/FIFO bits
// Assumes: Indexed 8-bit register space behind an index/data port pair
// Notes: Socket B sees the same indexes with the socket select bit of the index set
`ifndef CCPFR_MAP_VH
`define CCPFR_MAP_VH

`define CCPFR_IDX_MISC1 6'h16
`define CCPFR_IDX_WBUF 6'h17
`define CCPFR_IDX_PWRCLK 6'h1E
`define CCPFR_IDX_SOCK_BIT 6

`define CCPFR_MISC1_INPACK 7
`define CCPFR_WBUF_EMPTY 7

`define CCPFR_PC_BYPASS 0
`define CCPFR_PC_LOWPWR 1
`define CCPFR_PC_SUSPEND 2
`define CCPFR_PC_CORE5V 3
`define CCPFR_PC_LED 4
`define CCPFR_PC_FLOAT7 5
`define CCPFR_PC_DMA 6
`define CCPFR_PC_RING 7

`define CCPFR_MISC1_RST 8'h00
`define CCPFR_WBUF_RST 7'h00
`define CCPFR_PWRCLK_RST 8'h02

`define CCPFR_FLOAT_ADDR_A 16'h03F7
`define CCPFR_FLOAT_ADDR_B 16'h0377

`define CCPFR_CLK_PERIOD_NS 50
`define CCPFR_IDLE_HOLD_NS 400
`define CCPFR_IDLE_HOLD_CYC (`CCPFR_IDLE_HOLD_NS / `CCPFR_CLK_PERIOD_NS)

`endif

/* rtl/ccpfr_wfifo.v */
// Purpose: Posted-write buffer of one socket with flush
// Assumes: Push and pop handshakes are valid/ready in the same clock
// Notes: Flush beats a push in the same cycle; all flags are registered
`timescale 1ns/10ps
module ccpfr_wfifo #(
   parameter W = 8,
   parameter DEPTH = 4,
   parameter AW = 2
)(
   input wire clk_in,
   input wire rst_in,
   input wire flush_in,
   input wire push_valid_in,
   input wire [W-1:0] push_data_in,
   output wire push_ready_out,
   output wire pop_valid_out,
   output wire [W-1:0] pop_data_out,
   input wire pop_ready_in,
   output wire empty_out
);
   reg [W-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   reg full_r;
   reg empty_r;
   reg ready_r;
   wire push;
   wire pop;
   reg [AW:0] count_nxt;

   assign push = push_valid_in & ~full_r & ~flush_in;
   assign pop = pop_ready_in & ~empty_r & ~flush_in;
   assign push_ready_out = ready_r;
   assign pop_valid_out = ~empty_r;
   assign pop_data_out = mem_r[rd_ptr_r];
   assign empty_out = empty_r;

   always @*
   begin
      count_nxt = count_r;
      if (flush_in)
      begin
         count_nxt = {(AW+1){1'b0}};
      end
      else if (push & ~pop)
      begin
         count_nxt = count_r + 1'b1;
      end
      else if (pop & ~push)
      begin
         count_nxt = count_r - 1'b1;
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in | flush_in)
      begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
      end
   end

   always @(posedge clk_in)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= push_data_in;
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         count_r <= {(AW+1){1'b0}};
         full_r <= 1'b0;
         empty_r <= 1'b1;
         ready_r <= 1'b1;
      end
      else
      begin
         count_r <= count_nxt;
         full_r <= (count_nxt == DEPTH);
         // Own flop so the ready pin leaves straight from a register
         ready_r <= (count_nxt != DEPTH);
         empty_r <= (count_nxt == {(AW+1){1'b0}});
      end
   end
endmodule

/* rtl/ccpfr_regs.v */
// Purpose: Socket buffer control, data driver gating and chip power/clock control of a card socket controller
// Assumes: All inputs synchronous to CLK_IN; index/data port reached by one-cycle read and write strobes
// Notes: The real clock multiplier and gate sit outside; this block only steers them
// Behaviour
// RULE_01 - Inpack enable set: card inpack decides host data driving on socket reads
// RULE_02 - Buffer empty bit reads 1 when posted-write buffer empty, else 0
// RULE_03 - Writing 1 to the empty bit flushes the buffer; writing 0 does nothing
// RULE_04 - Software uses the scratch bits only while no card activity can happen
// RULE_05 - Buffer flushes while power good is low, card removed, or supply off
// RULE_06 - Software checks buffer empty before changing any socket timing register
// RULE_07 - Bypass clear runs time base at 7/4 input clock; set uses input clock
// RULE_08 - Auto clock stop set (reset value) stops clock when idle; clear runs always
// RULE_09 - Suspend stops synthesizer, forces low power and blocks socket access
// RULE_10 - Suspend with AEN high turns host bus inputs off
// RULE_11 - Host holds AEN high after entering suspend for lowest power
// RULE_12 - LED enable makes IRQ12 open drain, driven by speaker of LED sockets
// RULE_13 - Software keeps LED enable clear in memory card interface mode
// RULE_14 - Float control leaves data bit 7 undriven on socket reads at 03F7h/0377h
// RULE_15 - Dual-socket DMA bit reconfigures IRQ9, IRQ10, VPP valid; reserved single-socket
// RULE_16 - Buffer control register exists per socket at index 17h
// RULE_17 - Power and clock register exists once per chip at index 1Eh
// RULE_18 - Ring indicate bit makes IRQ15 pulse on falling card status change
// RULE_19 - Any host or card activity restarts the stopped internal clock first
`timescale 1ns/10ps
`include "ccpfr_map.vh"
module ccpfr_regs #(
   parameter NS = 2,
   parameter PW_W = 8,
   parameter PW_DEPTH = 4,
   parameter PW_AW = 2
)(
   input wire CLK_IN,
   input wire SYS_RST_IN,
   input wire IO_WR_IN,
   input wire IO_RD_IN,
   input wire IO_DATA_SEL_IN,
   input wire [7:0] IO_WDATA_IN,
   output wire [7:0] IO_RDATA_OUT,
   input wire AEN_IN,
   input wire POWER_GOOD_INPUT_IN,
   input wire [NS-1:0] CARD_PRESENT_IN,
   input wire [NS-1:0] VCC_POWER_IN,
   input wire [NS-1:0] CARD_INPACK_N_IN,
   input wire [NS-1:0] CARD_SPEAKER_N_IN,
   input wire [NS-1:0] SPEAKER_AS_LED_IN,
   input wire [NS-1:0] CARD_STATUS_CHANGE_N_IN,
   input wire SOCK_IO_RD_IN,
   input wire SOCK_SEL_IN,
   input wire [15:0] SOCK_IO_ADDR_IN,
   input wire [NS-1:0] PW_VALID_IN,
   input wire [PW_W-1:0] PW_DATA_IN,
   output wire [NS-1:0] PW_READY_OUT,
   output wire [NS-1:0] CARD_PW_VALID_OUT,
   output wire [NS*PW_W-1:0] CARD_PW_DATA_OUT,
   input wire [NS-1:0] CARD_PW_READY_IN,
   input wire IRQ12_REQ_IN,
   input wire IRQ15_REQ_IN,
   output wire DATA_LO_DRV_OUT,
   output wire DATA7_DRV_OUT,
   output wire SYNTH_EN_OUT,
   output wire SYNTH_BYPASS_OUT,
   output wire INT_CLK_RUN_OUT,
   output wire SOCKET_ACCESS_EN_OUT,
   output wire HOST_INPUTS_OFF_OUT,
   output wire CORE_5V_OUT,
   output wire IRQ12_OUT,
   output wire IRQ12_OE_OUT,
   output wire IRQ15_OUT,
   output wire DMA_MODE_OUT
);
   localparam integer IDLE_HOLD_CYC = `CCPFR_IDLE_HOLD_CYC;
   localparam [3:0] IDLE_HOLD = IDLE_HOLD_CYC[3:0];

   reg [7:0] index_r;
   reg [7:0] rdata_r;
   reg [7:0] pwrclk_r;
   reg [7:0] misc1_r [0:NS-1];
   reg [6:0] scratch_r [0:NS-1];
   reg [NS-1:0] flush_req_r;
   reg [NS-1:0] card_status_change_d_r;
   reg [3:0] idle_cnt_r;
   reg data_lo_drv_r;
   reg data7_drv_r;
   reg clk_run_r;
   reg inputs_off_r;
   reg irq12_r;
   reg irq12_oe_r;
   reg irq15_r;
   reg awake_r;
   reg [7:0] rdata_nxt;
   reg [3:0] idle_cnt_nxt;

   wire [5:0] reg_idx;
   wire sock;
   wire data_wr;
   wire data_rd;
   wire suspend;
   wire [NS-1:0] pw_empty;
   wire [NS-1:0] flush;
   wire [NS-1:0] led_on;
   wire [NS-1:0] card_status_change_fall;
   wire [NS-1:0] fifo_push;
   wire activity;
   wire sock_drv;
   wire float_hit;

   assign reg_idx = index_r[5:0];
   assign sock = (NS > 1) ? index_r[`CCPFR_IDX_SOCK_BIT] : 1'b0;
   assign data_wr = IO_WR_IN & IO_DATA_SEL_IN & ~inputs_off_r;
   assign data_rd = IO_RD_IN & IO_DATA_SEL_IN & ~inputs_off_r;
   assign suspend = pwrclk_r[`CCPFR_PC_SUSPEND];

   // Index register; host accesses are ignored while the bus inputs are off
   always @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         index_r <= 8'h00;
      end
      else if (IO_WR_IN & ~IO_DATA_SEL_IN & ~inputs_off_r)
      begin
         index_r <= IO_WDATA_IN;
      end
   end

   // Chip-wide register, one copy whatever the socket select says
   always @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         pwrclk_r <= `CCPFR_PWRCLK_RST;
         awake_r <= 1'b1;
      end
      else if (data_wr && reg_idx == `CCPFR_IDX_PWRCLK) // RULE_17
      begin
         pwrclk_r <= IO_WDATA_IN;
         awake_r <= ~IO_WDATA_IN[`CCPFR_PC_SUSPEND]; // RULE_09
         if (NS < 2)
         begin
            pwrclk_r[`CCPFR_PC_DMA] <= 1'b0; // RULE_15
         end
      end
   end

   genvar s;
   generate
      for (s = 0; s < NS; s = s + 1)
      begin : g_sock
         wire sel_wr;
         assign sel_wr = data_wr & (sock == s);

         always @(posedge CLK_IN)
         begin
            if (SYS_RST_IN)
            begin
               misc1_r[s] <= `CCPFR_MISC1_RST;
               scratch_r[s] <= `CCPFR_WBUF_RST;
               flush_req_r[s] <= 1'b0;
            end
            else
            begin
               flush_req_r[s] <= 1'b0;
               if (sel_wr && reg_idx == `CCPFR_IDX_MISC1)
               begin
                  misc1_r[s] <= IO_WDATA_IN;
               end
               if (sel_wr && reg_idx == `CCPFR_IDX_WBUF) // RULE_16
               begin
                  scratch_r[s] <= IO_WDATA_IN[6:0];
                  flush_req_r[s] <= IO_WDATA_IN[`CCPFR_WBUF_EMPTY]; // RULE_03
               end
            end
         end

         // Loss conditions act every cycle they hold, not only on their edge
         assign flush[s] = flush_req_r[s] | ~POWER_GOOD_INPUT_IN | ~CARD_PRESENT_IN[s] | ~VCC_POWER_IN[s]; // RULE_05
         assign fifo_push[s] = PW_VALID_IN[s] & ~suspend; // RULE_09

         ccpfr_wfifo #(
            .W(PW_W),
            .DEPTH(PW_DEPTH),
            .AW(PW_AW)
         ) u_wfifo (
            .clk_in(CLK_IN),
            .rst_in(SYS_RST_IN),
            .flush_in(flush[s]),
            .push_valid_in(fifo_push[s]),
            .push_data_in(PW_DATA_IN),
            .push_ready_out(PW_READY_OUT[s]),
            .pop_valid_out(CARD_PW_VALID_OUT[s]),
            .pop_data_out(CARD_PW_DATA_OUT[s*PW_W +: PW_W]),
            .pop_ready_in(CARD_PW_READY_IN[s] & ~suspend),
            .empty_out(pw_empty[s])
         );

         assign led_on[s] = ~CARD_SPEAKER_N_IN[s] & SPEAKER_AS_LED_IN[s]; // RULE_12
         assign card_status_change_fall[s] = card_status_change_d_r[s] & ~CARD_STATUS_CHANGE_N_IN[s];
      end
   endgenerate

   // Read mux; unmapped indexes read as zero
   always @*
   begin
      rdata_nxt = rdata_r;
      if (IO_RD_IN & ~IO_DATA_SEL_IN & ~inputs_off_r)
      begin
         rdata_nxt = index_r;
      end
      else if (data_rd)
      begin
         case (reg_idx)
            `CCPFR_IDX_MISC1: rdata_nxt = misc1_r[sock];
            `CCPFR_IDX_WBUF: rdata_nxt = {pw_empty[sock], scratch_r[sock]}; // RULE_02
            `CCPFR_IDX_PWRCLK: rdata_nxt = pwrclk_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // Socket read data drivers; inpack only matters once software opts in
   assign sock_drv = SOCK_IO_RD_IN & ~suspend &
                     (~misc1_r[SOCK_SEL_IN][`CCPFR_MISC1_INPACK] | ~CARD_INPACK_N_IN[SOCK_SEL_IN]); // RULE_01
   assign float_hit = pwrclk_r[`CCPFR_PC_FLOAT7] &
                      (SOCK_IO_ADDR_IN == `CCPFR_FLOAT_ADDR_A || SOCK_IO_ADDR_IN == `CCPFR_FLOAT_ADDR_B); // RULE_14

   always @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         data_lo_drv_r <= 1'b0;
         data7_drv_r <= 1'b0;
      end
      else
      begin
         data_lo_drv_r <= sock_drv; // RULE_01
         data7_drv_r <= sock_drv & ~float_hit; // RULE_14
      end
   end

   // Activity keeps the clock alive; the hold count covers short gaps between cycles
   assign activity = IO_WR_IN | IO_RD_IN | SOCK_IO_RD_IN | (|PW_VALID_IN) | (|CARD_PW_VALID_OUT) |
                     (|card_status_change_fall); // RULE_19

   always @*
   begin
      idle_cnt_nxt = idle_cnt_r;
      if (activity)
      begin
         idle_cnt_nxt = IDLE_HOLD;
      end
      else if (idle_cnt_r != 4'h0)
      begin
         idle_cnt_nxt = idle_cnt_r - 4'h1;
      end
   end

   always @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         idle_cnt_r <= 4'h0;
         clk_run_r <= 1'b1;
         inputs_off_r <= 1'b0;
         card_status_change_d_r <= {NS{1'b1}};
      end
      else
      begin
         idle_cnt_r <= idle_cnt_nxt;
         // Suspend forces the stop-when-idle behaviour on regardless of the mode bit
         clk_run_r <= (~pwrclk_r[`CCPFR_PC_LOWPWR] & ~suspend) | activity | (idle_cnt_r != 4'h0); // RULE_08 RULE_09 RULE_19
         inputs_off_r <= suspend & AEN_IN; // RULE_10
         card_status_change_d_r <= CARD_STATUS_CHANGE_N_IN;
      end
   end

   // Interrupt pin functions
   always @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         irq12_r <= 1'b0;
         irq12_oe_r <= 1'b1;
         irq15_r <= 1'b0;
      end
      else
      begin
         if (pwrclk_r[`CCPFR_PC_LED])
         begin
            irq12_r <= 1'b0;
            irq12_oe_r <= |led_on; // RULE_12
         end
         else
         begin
            irq12_r <= IRQ12_REQ_IN;
            irq12_oe_r <= 1'b1;
         end
         irq15_r <= pwrclk_r[`CCPFR_PC_RING] ? (|card_status_change_fall) : IRQ15_REQ_IN; // RULE_18
      end
   end

   assign IO_RDATA_OUT = rdata_r;
   assign DATA_LO_DRV_OUT = data_lo_drv_r;
   assign DATA7_DRV_OUT = data7_drv_r;
   assign SYNTH_EN_OUT = awake_r; // RULE_09
   assign SYNTH_BYPASS_OUT = pwrclk_r[`CCPFR_PC_BYPASS]; // RULE_07
   assign INT_CLK_RUN_OUT = clk_run_r;
   assign SOCKET_ACCESS_EN_OUT = awake_r; // RULE_09
   assign HOST_INPUTS_OFF_OUT = inputs_off_r;
   assign CORE_5V_OUT = pwrclk_r[`CCPFR_PC_CORE5V];
   assign IRQ12_OUT = irq12_r;
   assign IRQ12_OE_OUT = irq12_oe_r;
   assign IRQ15_OUT = irq15_r;
   assign DMA_MODE_OUT = pwrclk_r[`CCPFR_PC_DMA]; // RULE_15
endmodule

/* dv/ccpfr_asserts.sv */
// Purpose: Port-level checks of the card controller power and buffer bits
// Assumes: One clock domain, synchronous active-high reset
// Notes: Register contents are not visible here, so outputs are tied to each other and to inputs
`timescale 1ns/10ps
module ccpfr_asserts #(
   parameter NS = 2
)(
   input wire CLK_IN,
   input wire SYS_RST_IN,
   input wire IO_WR_IN,
   input wire IO_RD_IN,
   input wire AEN_IN,
   input wire POWER_GOOD_INPUT_IN,
   input wire [NS-1:0] CARD_PRESENT_IN,
   input wire [NS-1:0] VCC_POWER_IN,
   input wire [NS-1:0] CARD_STATUS_CHANGE_N_IN,
   input wire SOCK_IO_RD_IN,
   input wire [15:0] SOCK_IO_ADDR_IN,
   input wire [NS-1:0] CARD_PW_VALID_OUT,
   input wire IRQ15_REQ_IN,
   input wire DATA_LO_DRV_OUT,
   input wire DATA7_DRV_OUT,
   input wire SYNTH_EN_OUT,
   input wire INT_CLK_RUN_OUT,
   input wire SOCKET_ACCESS_EN_OUT,
   input wire HOST_INPUTS_OFF_OUT,
   input wire IRQ15_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // Quiet status line, so no ring pulse may follow
   sequence s_quiet;
      !IRQ15_REQ_IN && $stable(CARD_STATUS_CHANGE_N_IN);
   endsequence
   property p_host_off;
      (!SOCKET_ACCESS_EN_OUT && AEN_IN) |=> HOST_INPUTS_OFF_OUT;
   endproperty
   a_host_off: assert property (p_host_off) else $error("host inputs not off");
   property p_synth;
      SYNTH_EN_OUT == SOCKET_ACCESS_EN_OUT;
   endproperty
   a_synth: assert property (p_synth) else $error("synth run and access differ");
   property p_loss;
      (!POWER_GOOD_INPUT_IN || !CARD_PRESENT_IN[0] || !VCC_POWER_IN[0]) |=> !CARD_PW_VALID_OUT[0];
   endproperty
   a_loss: assert property (p_loss) else $error("buffer kept data on loss");
   property p_susp_block;
      (!SOCKET_ACCESS_EN_OUT && !CARD_PW_VALID_OUT[0]) |=> !CARD_PW_VALID_OUT[0];
   endproperty
   a_susp_block: assert property (p_susp_block) else $error("push taken in suspend");
   property p_susp_drv;
      !SOCKET_ACCESS_EN_OUT |=> !DATA_LO_DRV_OUT && !DATA7_DRV_OUT;
   endproperty
   a_susp_drv: assert property (p_susp_drv) else $error("socket read driven in suspend");
   property p_drv_idle;
      !SOCK_IO_RD_IN |=> !DATA_LO_DRV_OUT && !DATA7_DRV_OUT;
   endproperty
   a_drv_idle: assert property (p_drv_idle) else $error("data driven without read");
   property p_d7_norm;
      SOCK_IO_RD_IN && SOCK_IO_ADDR_IN != 16'h03F7 && SOCK_IO_ADDR_IN != 16'h0377
         |=> DATA7_DRV_OUT == DATA_LO_DRV_OUT;
   endproperty
   a_d7_norm: assert property (p_d7_norm) else $error("bit 7 gated off float address");
   property p_wake;
      (IO_WR_IN || IO_RD_IN) && !HOST_INPUTS_OFF_OUT |=> INT_CLK_RUN_OUT;
   endproperty
   a_wake: assert property (p_wake) else $error("clock not restarted by access");
   property p_ring_quiet;
      s_quiet [*3] |=> !IRQ15_OUT;
   endproperty
   a_ring_quiet: assert property (p_ring_quiet) else $error("irq15 without cause");
endmodule
bind ccpfr_regs ccpfr_asserts #(.NS(NS)) u_chk (.*);

/* dv/ccpfr_card_model.sv */
// Purpose: Card-side drain of the posted-write buffers
// Assumes: Pop is valid and ready in the same clock
// Notes: Stall holds ready low so the buffer backs up, as a slow card would
`timescale 1ns/10ps
module ccpfr_card_model (
   input wire clk_in,
   input wire stall_in,
   input wire [1:0] valid_in,
   input wire [15:0] data_in,
   output wire [1:0] ready_out
);
   reg [7:0] got_r [0:3];
   reg [1:0] n_r = 2'h0;
   assign ready_out = stall_in ? 2'h0 : 2'h3;
   always @(posedge clk_in)
   begin
      if (valid_in[0] && ready_out[0])
      begin
         got_r[n_r] <= data_in[7:0];
         n_r <= n_r + 2'h1;
      end
   end
endmodule

/* dv/tb_card_ctrl_power_fifo_regs.sv */
// Purpose: Self-checking bench of the card controller power and buffer bits
// Assumes: Inputs change at the falling edge, index then data access
// Notes: Socket timing is never changed, so no empty check precedes it
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) \
   begin n_fail = n_fail + 1; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_card_ctrl_power_fifo_regs;
   reg clk, rst, wr, rd, sel, aen, pg, srd, ssel, stall, i12, i15;
   reg [7:0] wd, pwd;
   reg [15:0] sadr;
   reg [1:0] pres, vcc, inp_n, spk_n, led, sts_n, pwv;
   wire [7:0] rdata;
   wire [1:0] pwr, cpv, cpr;
   wire [15:0] cpd;
   wire lo, d7, syn, byp, run, sae, hoff, c5, q12, oe12, q15, dma;
   integer n_fail = 0, tests_run = 0, k, hit;
   ccpfr_regs dut (.CLK_IN(clk), .SYS_RST_IN(rst), .IO_WR_IN(wr), .IO_RD_IN(rd), .IO_DATA_SEL_IN(sel),
      .IO_WDATA_IN(wd), .IO_RDATA_OUT(rdata), .AEN_IN(aen), .POWER_GOOD_INPUT_IN(pg), .CARD_PRESENT_IN(pres),
      .VCC_POWER_IN(vcc), .CARD_INPACK_N_IN(inp_n), .CARD_SPEAKER_N_IN(spk_n), .SPEAKER_AS_LED_IN(led),
      .CARD_STATUS_CHANGE_N_IN(sts_n), .SOCK_IO_RD_IN(srd), .SOCK_SEL_IN(ssel), .SOCK_IO_ADDR_IN(sadr),
      .PW_VALID_IN(pwv), .PW_DATA_IN(pwd), .PW_READY_OUT(pwr), .CARD_PW_VALID_OUT(cpv), .CARD_PW_DATA_OUT(cpd),
      .CARD_PW_READY_IN(cpr), .IRQ12_REQ_IN(i12), .IRQ15_REQ_IN(i15), .DATA_LO_DRV_OUT(lo), .DATA7_DRV_OUT(d7),
      .SYNTH_EN_OUT(syn), .SYNTH_BYPASS_OUT(byp), .INT_CLK_RUN_OUT(run), .SOCKET_ACCESS_EN_OUT(sae),
      .HOST_INPUTS_OFF_OUT(hoff), .CORE_5V_OUT(c5), .IRQ12_OUT(q12), .IRQ12_OE_OUT(oe12), .IRQ15_OUT(q15),
      .DMA_MODE_OUT(dma));
   ccpfr_card_model model (.clk_in(clk), .stall_in(stall), .valid_in(cpv), .data_in(cpd), .ready_out(cpr));
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task idle(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task wr_reg(input [7:0] i, input [7:0] d);
   begin
      @(negedge clk) {wr, sel, wd} = {2'b10, i};
      @(negedge clk) {sel, wd} = {1'b1, d};
      @(negedge clk) wr = 0;
   end
   endtask
   task rd_reg(input [7:0] i, input [7:0] e);
   begin
      @(negedge clk) {wr, sel, wd} = {2'b10, i};
      @(negedge clk) {wr, rd, sel} = 3'b011;
      @(negedge clk) rd = 0;
      `CHK("rdata", e, rdata)
   end
   endtask
   task push(input [7:0] d);
   begin
      @(negedge clk) {pwv, pwd} = {2'b01, d};
      @(negedge clk) pwv = 0;
   end
   endtask
   task sockrd(input [15:0] a, input [1:0] e);
   begin
      @(negedge clk) {srd, sadr} = {1'b1, a};
      @(negedge clk) `CHK("drivers", e, {lo, d7})
      srd = 0;
   end
   endtask
   task test_done;
   begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   initial
   begin
      #2000000 n_fail = n_fail + 1;
      test_done;
   end
   initial
   begin
      {wr, rd, sel, aen, srd, ssel, i12, i15, pwv, wd, pwd, sadr, led} = 0;
      {pg, stall, rst} = 3'b111;
      {pres, vcc, inp_n, spk_n, sts_n} = 10'h3FF;
      idle(6);
      rst = 0;
      idle(12);
      `CHK("clk_run", 1'b0, run)
      `CHK("pc_rst", 3'b001, {byp, dma, syn})
      `CHK("pw_ready", 2'b11, pwr)
      i12 = 1;
      idle(2);
      `CHK("irq12", 2'b11, {q12, oe12})
      rd_reg(8'h1E, 8'h02);
      `CHK("wake", 1'b1, run)
      rd_reg(8'h17, 8'h80);
      rd_reg(8'h20, 8'h00);
      wr_reg(8'h57, 8'h15);
      rd_reg(8'h57, 8'h95);
      rd_reg(8'h17, 8'h80);
      $display("test registers done");
      push(8'hA5);
      rd_reg(8'h17, 8'h00);
      wr_reg(8'h17, 8'h00);
      rd_reg(8'h17, 8'h00);
      wr_reg(8'h17, 8'h80);
      rd_reg(8'h17, 8'h80);
      for (k = 0; k < 3; k = k + 1)
      begin
         push(8'h3C);
         `CHK("queued", 1'b1, cpv[0])
         {pg, pres[0], vcc[0]} = ~(3'b100 >> k);
         @(negedge clk) {pg, pres, vcc} = 5'h1F;
         @(negedge clk) `CHK("lost", 1'b0, cpv[0])
      end
      repeat (4) push(8'h44);
      `CHK("full", 1'b0, pwr[0])
      wr_reg(8'h17, 8'h80);
      idle(1);
      `CHK("flushed", 2'b10, {pwr[0], cpv[0]})
      stall = 0;
      push(8'h11);
      push(8'h22);
      idle(3);
      `CHK("pop", 16'h1122, {model.got_r[0], model.got_r[1]})
      $display("test buffer done");
      rd_reg(8'h17, 8'h80);
      wr_reg(8'h1E, 8'h49);
      idle(1);
      `CHK("pc_bits", 3'b111, {byp, dma, c5})
      rd_reg(8'h1E, 8'h49);
      wr_reg(8'h1E, 8'h00);
      idle(12);
      `CHK("clk_run", 1'b1, run)
      wr_reg(8'h1E, 8'h04);
      idle(1);
      `CHK("suspend", 2'b00, {syn, sae})
      push(8'h77);
      `CHK("susp_push", 1'b0, cpv[0])
      sockrd(16'h0300, 2'b00);
      aen = 1;
      idle(2);
      `CHK("inputs_off", 1'b1, hoff)
      wr_reg(8'h1E, 8'h00);
      aen = 0;
      idle(2);
      rd_reg(8'h1E, 8'h04);
      $display("test suspend done");
      wr_reg(8'h1E, 8'h20);
      sockrd(16'h03F7, 2'b10);
      sockrd(16'h0377, 2'b10);
      sockrd(16'h03F6, 2'b11);
      wr_reg(8'h16, 8'h80);
      sockrd(16'h0300, 2'b00);
      inp_n = 2'b10;
      sockrd(16'h0300, 2'b11);
      wr_reg(8'h1E, 8'h10);
      {led, spk_n} = 4'b0110;
      idle(2);
      `CHK("led_on", 2'b01, {q12, oe12})
      spk_n = 2'b11;
      idle(2);
      `CHK("led_off", 1'b0, oe12)
      wr_reg(8'h1E, 8'h80);
      sts_n = 2'b10;
      hit = 0;
      repeat (4) @(negedge clk) hit = hit | q15;
      `CHK("ring", 1, hit)
      $display("test pins done");
      test_done;
   end
endmodule
